// File: hw/camera_general_purpose_io.sv
// general-purpose output drive, input status, debounce and change events
// How it works
// - alarm output line follows output level setting: high supply, low ground.
// - input level status reads true when input line is at supply level.
// - with events configured, each input state change that passes the filter emits one event pulse.
// - event route selector must equal 2 to route the input line.
// - event source selector must equal 5 to pick routed interrupt queue.
// - event delivery selector must equal 3 for network protocol events.
// - filter window holds input changes for window times 400 ns steps (~480 ns rounded down to whole cycles).
// - window resets to zero; zero passes transitions unfiltered.
// - window accepts any value up to 65535, about 26 ms.
`timescale 1ns/1ps
module camera_general_purpose_io
    import gpio_pkg::*;
#(
    parameter int STEP = gpio_pkg::STEP_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // pins
    input wire logic general_input_line,
    output logic alarm_output_line,
    // settings
    input wire logic output_level_setting,
    input wire logic [gpio_pkg::WINDOW_W-1:0] input_filter_window,
    input wire logic [gpio_pkg::SEL_W-1:0] event_route_selector,
    input wire logic [gpio_pkg::SEL_W-1:0] event_source_selector,
    input wire logic [gpio_pkg::SEL_W-1:0] event_delivery_selector,
    // status and events
    output logic input_level_status,
    output logic input_event
);
    import gpio_pkg::*;

    if (STEP < 1 || STEP > 255) begin : g_step_check
        $error("STEP must be 1..255");
    end

    logic sync_a;
    logic sync_b;
    logic filtered;
    logic [7:0] step_cnt;
    logic [WINDOW_W-1:0] hold_cnt;
    // the window value is held in a register so its reset value is defined
    logic [WINDOW_W-1:0] window;

    wire step_tick = (step_cnt == 8'(STEP - 1));
    wire differs = (sync_b != filtered);
    wire bypass = (window == WINDOW_RESET);
    wire window_done = step_tick && (hold_cnt >= window - 16'h0001);
    wire accept = differs && (bypass || window_done);
    wire events_on = (event_route_selector == ROUTE_INPUT_LINE)
        && (event_source_selector == SOURCE_ROUTED_QUEUE)
        && (event_delivery_selector == DELIVERY_NETWORK_EVENT);

    // two stages before any use; first stage read by the second only
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= general_input_line;
            sync_b <= sync_a;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            window <= WINDOW_RESET;
        end else begin
            window <= input_filter_window;
        end
    end

    // a new level must stay stable for the whole window; any bounce restarts it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            step_cnt <= 8'h00;
            hold_cnt <= 16'h0000;
        end else if (!differs || accept) begin
            step_cnt <= 8'h00;
            hold_cnt <= 16'h0000;
        end else if (step_tick) begin
            step_cnt <= 8'h00;
            hold_cnt <= hold_cnt + 16'h0001;
        end else begin
            step_cnt <= step_cnt + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            filtered <= 1'b0;
            input_level_status <= 1'b0;
            input_event <= 1'b0;
            alarm_output_line <= 1'b0;
        end else begin
            if (accept) begin
                filtered <= sync_b;
            end
            input_level_status <= accept ? sync_b : filtered;
            input_event <= accept && events_on;
            alarm_output_line <= output_level_setting;
        end
    end

    // independent count of cycles the synchronised level has differed;
    // the window checks assume the window is not moved during a wait
    localparam int RUN_W = WINDOW_W + 8;
    logic [RUN_W-1:0] diff_run;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            diff_run <= '0;
        end else if (!differs || accept) begin
            diff_run <= '0;
        end else begin
            diff_run <= diff_run + RUN_W'(1);
        end
    end

    sequence s_stable_change;
        bypass && differs;
    endsequence

    sequence s_window_open;
        !bypass && differs;
    endsequence

    sequence s_event_out;
        input_event;
    endsequence

    a_output_follows: assert property (
        @(posedge core_clk) disable iff (!resetn)
        alarm_output_line == $past(output_level_setting)
    ) else $error("alarm output does not follow setting");

    // with the filter off the status is the pin three edges back
    a_status_tracks: assert property (
        @(posedge core_clk) disable iff (!resetn)
        $past(bypass)
        |-> input_level_status == $past(general_input_line, 3)
    ) else $error("status differs from input line");

    a_status_steady: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !$past(differs)
        |-> $stable(input_level_status)
    ) else $error("status moved without an input change");

    a_event_on_change: assert property (
        @(posedge core_clk) disable iff (!resetn)
        s_event_out
        |-> $past(events_on) && $changed(filtered)
    ) else $error("event without a configured change");

    a_event_fires: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && events_on
        |=> input_event
    ) else $error("configured change gave no event");

    a_event_moves_status: assert property (
        @(posedge core_clk) disable iff (!resetn)
        s_event_out
        |-> $changed(input_level_status)
    ) else $error("event without a status change");

    a_route_gate: assert property (
        @(posedge core_clk) disable iff (!resetn)
        $past(event_route_selector) != ROUTE_INPUT_LINE
        |-> !input_event
    ) else $error("event with wrong route");

    a_source_gate: assert property (
        @(posedge core_clk) disable iff (!resetn)
        $past(event_source_selector) != SOURCE_ROUTED_QUEUE
        |-> !input_event
    ) else $error("event with wrong source");

    a_delivery_gate: assert property (
        @(posedge core_clk) disable iff (!resetn)
        $past(event_delivery_selector) != DELIVERY_NETWORK_EVENT
        |-> !input_event
    ) else $error("event with wrong delivery");

    a_bypass_pass: assert property (
        @(posedge core_clk) disable iff (!resetn)
        s_stable_change
        |=> filtered == $past(sync_b)
    ) else $error("zero window did not pass input");

    a_window_holds: assert property (
        @(posedge core_clk) disable iff (!resetn)
        s_window_open ##0 (int'(diff_run) < int'(window) * STEP - 1)
        |=> $stable(filtered)
    ) else $error("filtered level changed before window");

    a_window_exact: assert property (
        @(posedge core_clk) disable iff (!resetn)
        accept && !bypass
        |-> int'(diff_run) == int'(window) * STEP - 1
    ) else $error("filtered level changed after wrong hold");

    a_bounce_restart: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !differs
        |=> hold_cnt == 16'h0000 && step_cnt == 8'h00
    ) else $error("bounce did not restart the window");

    a_step_bound: assert property (
        @(posedge core_clk) disable iff (!resetn)
        step_cnt <= 8'(STEP - 1)
    ) else $error("step counter overran");

    a_sync_depth: assert property (
        @(posedge core_clk) disable iff (!resetn)
        sync_b == $past(general_input_line, 2)
    ) else $error("synchroniser depth wrong");

    a_window_range: assert property (
        @(posedge core_clk) disable iff (!resetn)
        window == $past(input_filter_window)
    ) else $error("window setting not taken in full");
endmodule

// File: hw/gpio_pkg.sv
// constants for the camera general-purpose input/output block
package gpio_pkg;
    localparam int STEP_NS = 480;
    localparam int CLK_PERIOD_NS = 100;
    // ~480 ns step rounded down to whole cycles, at least one
    localparam int STEP_CYCLES = (STEP_NS / CLK_PERIOD_NS) < 1 ? 1 : (STEP_NS / CLK_PERIOD_NS);
    localparam int WINDOW_W = 16;
    localparam logic [15:0] WINDOW_RESET = 16'h0000;
    localparam logic [15:0] WINDOW_MAX = 16'hffff;
    localparam int SEL_W = 4;
    localparam logic [3:0] ROUTE_INPUT_LINE = 4'h2;
    localparam logic [3:0] SOURCE_ROUTED_QUEUE = 4'h5;
    localparam logic [3:0] DELIVERY_NETWORK_EVENT = 4'h3;
endpackage

// File: sim/io_equipment.sv
// external control equipment driving the general input line
`timescale 1ns/1ps
module io_equipment (
    // clock
    input wire logic core_clk,
    // commands from the bench
    input wire logic level,
    input wire logic bounce,
    // pin
    output logic general_input_line
);
    logic chatter = 1'b0;
    // contacts chatter every cycle while bouncing, so filters get a real fight
    always @(posedge core_clk) begin
        chatter <= ~chatter;
    end
    assign general_input_line = bounce ? chatter : level;
endmodule

// File: sim/testbench.sv
// self-checking bench for the general-purpose io block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module testbench;
    import gpio_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic level = 1'b0;
    logic bounce = 1'b0;
    logic out_set = 1'b0;
    logic [15:0] window = 16'h0000;
    logic [3:0] route = ROUTE_INPUT_LINE;
    logic [3:0] source = SOURCE_ROUTED_QUEUE;
    logic [3:0] delivery = DELIVERY_NETWORK_EVENT;
    logic pin, alarm, status, ev;
    int fails = 0;
    int checks_done = 0;
    int n;
    io_equipment i_eq (.core_clk(core_clk), .level(level), .bounce(bounce),
        .general_input_line(pin));
    camera_general_purpose_io #(.STEP(STEP_CYCLES)) i_dut (.core_clk(core_clk), .resetn(resetn),
        .general_input_line(pin), .alarm_output_line(alarm), .output_level_setting(out_set),
        .input_filter_window(window), .event_route_selector(route),
        .event_source_selector(source), .event_delivery_selector(delivery),
        .input_level_status(status), .input_event(ev));
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // unfiltered change: status and event land on the third edge
    task automatic toggle_check(input logic fire);
        @(posedge core_clk) level <= ~level;
        step(2);
        `CHK("status early", ~level, status)
        step(1);
        `CHK("status", level, status)
        `CHK("event", fire, ev)
        step(1);
        `CHK("event end", 1'b0, ev)
    endtask
    initial begin
        step(8);
        `CHK("status reset", 1'b0, status)
        @(posedge core_clk) resetn <= 1'b1;
        @(posedge core_clk) out_set <= 1'b1;
        step(1);
        `CHK("alarm high", 1'b1, alarm)
        @(posedge core_clk) out_set <= 1'b0;
        step(1);
        `CHK("alarm low", 1'b0, alarm)
        for (n = 0; n < 4; n++) begin
            @(posedge core_clk);
            route <= (n == 0) ? 4'h1 : ROUTE_INPUT_LINE;
            source <= (n == 1) ? 4'h4 : SOURCE_ROUTED_QUEUE;
            delivery <= (n == 2) ? 4'h2 : DELIVERY_NETWORK_EVENT;
            step(2);
            toggle_check(n == 3);
        end
        @(posedge core_clk) window <= 16'h0002;
        @(posedge core_clk) bounce <= 1'b1;
        repeat (4) begin
            step(1);
            `CHK("bounce status", 1'b0, status)
            `CHK("bounce event", 1'b0, ev)
        end
        @(posedge core_clk) bounce <= 1'b0;
        step(12);
        `CHK("bounce held off", level, status)
        // two synchroniser edges, then the window of two steps
        @(posedge core_clk) level <= ~level;
        for (n = 1; n < 40; n++) begin
            step(1);
            if (status === level) break;
        end
        `CHK("filter delay", 2 + 2 * STEP_CYCLES, n)
        `CHK("filtered event", 1'b1, ev)
        @(posedge core_clk) window <= 16'hffff;
        step(2);
        @(posedge core_clk) level <= ~level;
        step(40);
        `CHK("max window", ~level, status)
        final_report();
    end
endmodule
